// File: rtl/chan_cfg.svh
// constants for the multicycle block channel and its peripheral ends
// assumes one 200 MHz clock shared by both ends of the link
`ifndef CHAN_CFG_SVH
`define CHAN_CFG_SVH

`define WORD_W          18
`define CODE_W          15
`define VPI_LEVELS      8
`define CHAIN_MAX       8
`define CLK_MHZ         200
`define IOP_CYCLE_NS    1000
`define IOP_CYCLE_CLK   ((`IOP_CYCLE_NS * `CLK_MHZ) / 1000)
`define SETTLE_CNT_W    8
`define WORD_ZERO       18'h00000
`define WORD_ONE        18'h00001
`define CODE_ZERO       15'h0000

`endif

// File: rtl/chan_pkg.sv
// types shared by the channel controller and the peripheral end
// assumes chan_cfg.svh is on the include path
`include "chan_cfg.svh"

package chan_pkg;

  typedef logic [`WORD_W-1:0] word_type;
  typedef logic [`CODE_W-1:0] code_type;

  // which class of i/o activity is being served, lowest first
  typedef enum logic [2:0] {
    SVC_MAIN,
    SVC_SHARED,
    SVC_VPI,
    SVC_RTC,
    SVC_CHAN
  } svc_class_type;

endpackage : chan_pkg

// File: rtl/chan_link_if.sv
// link between the channel controller and the first peripheral of the chain
// assumes both ends run on the same clock; no clocking block here
interface chan_link_if;
  import chan_pkg::*;

  logic     req;        // block_channel request, chain wired-or
  logic     grant;      // one-cycle grant pulse
  logic     addr_valid; // one-cycle pulse with the word-count code
  code_type addr;       // fixed code: address of the word-count location
  logic     dir_out;    // 1: memory to peripheral
  word_type wdata;      // peripheral to memory word, held while busy
  word_type rdata;      // memory to peripheral word
  logic     strobe;     // one-cycle pulse: rdata valid into buffer
  logic     done;       // one-cycle pulse: transfer finished
  logic     overflow;   // one-cycle pulse with done: count rolled over

  modport ctrl (
    input  req, addr_valid, addr, dir_out, wdata,
    output grant, rdata, strobe, done, overflow
  );

  modport periph (
    output req, addr_valid, addr, dir_out, wdata,
    input  grant, rdata, strobe, done, overflow
  );

endinterface : chan_link_if

// File: rtl/chan_ctrl.sv
// multicycle block channel controller inside the i/o processor
// assumes a memory port that takes a request when MEM_REQ and MEM_ACK
// are both high, and peripherals joined through chan_link_if
//
// Notes on behaviour
// - ranks channel, clock, vectored, shared, main
// - simultaneous requests: channel served first
// - channel waits for current activity to end
// - one channel, eight chained mixed controllers
// - channel memory use locks out the cpu
// - software puts count below address in memory
// - count is minus words, address minus one
// - program enables controller before it requests
// - input request only with buffer full
// - pending channel request answered with grant
// - after grant controller drives word-count code
// - code stored, memory cycle, code to latch
// - cycle one: count read, incremented, rewritten
// - cycle two: code plus one, address incremented
// - cycle three: new address selects data word
// - input: memory handshake again, word written
// - output: a full i/o cycle of settling before strobe
// - count rollover tells peripheral to stop
// - count zero raises block-end interrupt
// - 18-bit words in either direction
// - input and output rates set by cycle count
`include "chan_cfg.svh"
module chan_ctrl (
  input  wire logic                  CLK,
  input  wire logic                  SYS_RST,
  input  wire logic                  CE,
  chan_link_if.ctrl                  LINK,
  input  wire logic                  RTC_REQ,
  input  wire logic [`VPI_LEVELS-1:0] VPI_REQ,
  input  wire logic                  SHARED_INT_REQ,
  input  wire logic                  OTHER_BUSY,
  input  wire logic                  CPU_MEM_REQ,
  output logic                       CPU_MEM_GRANT,
  output chan_pkg::svc_class_type    SERVICE_CLASS,
  output logic [2:0]                 VPI_LEVEL,
  output logic                       CHAN_BUSY,
  output logic                       MEM_REQ,
  output logic                       MEM_WE,
  output chan_pkg::word_type         MEM_ADDR,
  output chan_pkg::word_type         MEM_WDATA,
  input  wire chan_pkg::word_type    MEM_RDATA,
  input  wire logic                  MEM_ACK,
  output logic                       BLOCK_END_IRQ
);
  import chan_pkg::*;

  typedef enum logic [3:0] {
    IDLE,
    ADDR_WAIT,
    WC_RD,
    WC_WR,
    CA_RD,
    CA_WR,
    DATA_MEM,
    SETTLE,
    FINISH
  } ctrl_state_type;

  typedef struct packed {
    ctrl_state_type            st;
    code_type                  code;
    word_type                  memory_address_latch;
    logic                      dir_out;
    logic                      wc_carry;
    logic [`SETTLE_CNT_W-1:0]  settle;
    logic                      grant;
    word_type                  rdata;
    logic                      strobe;
    logic                      done;
    logic                      overflow;
    logic                      block_end;
    logic                      cpu_grant;
    logic                      busy;
    svc_class_type             svc;
    logic [2:0]                vpi_level;
    logic                      mem_req;
    logic                      mem_we;
    word_type                  mem_addr;
    word_type                  mem_wdata;
  } ctrl_regs_type;

  localparam logic [`SETTLE_CNT_W-1:0] SETTLE_LAST =
    `SETTLE_CNT_W'(`IOP_CYCLE_CLK - 1);

  ctrl_regs_type s_r;
  ctrl_regs_type s_nxt;

  logic                   mem_taken;
  logic [`WORD_W:0]       inc_sum;
  logic [`WORD_W-1:0]     code_word;

  assign mem_taken = s_r.mem_req && MEM_ACK;
  // one adder serves count and address increments; the code plus one has its own adder
  assign inc_sum   = {1'b0, MEM_RDATA} + {1'b0, `WORD_ONE};
  assign code_word = {{(`WORD_W-`CODE_W){1'b0}}, s_r.code};

  always_comb begin
    s_nxt           = s_r;
    s_nxt.grant     = 1'b0;
    s_nxt.strobe    = 1'b0;
    s_nxt.done      = 1'b0;
    s_nxt.overflow  = 1'b0;
    s_nxt.block_end = 1'b0;

    // priority among i/o classes, refreshed every cycle that CE is high
    s_nxt.vpi_level = 3'h0;
    for (int i = `VPI_LEVELS - 1; i >= 0; i--) begin
      if (VPI_REQ[i]) begin
        s_nxt.vpi_level = 3'(i);
      end
    end
    if (LINK.req || s_r.st != IDLE) begin
      s_nxt.svc = SVC_CHAN;
    end else if (RTC_REQ) begin
      s_nxt.svc = SVC_RTC;
    end else if (|VPI_REQ) begin
      s_nxt.svc = SVC_VPI;
    end else if (SHARED_INT_REQ) begin
      s_nxt.svc = SVC_SHARED;
    end else begin
      s_nxt.svc = SVC_MAIN;
    end

    // cpu only reaches memory while the channel neither runs nor asks
    s_nxt.cpu_grant = CPU_MEM_REQ && s_nxt.st == IDLE && !LINK.req;

    case (s_r.st)
      IDLE: begin
        // a running lower activity is never cut short
        if (LINK.req && !OTHER_BUSY) begin
          s_nxt.grant     = 1'b1;
          s_nxt.cpu_grant = 1'b0;
          s_nxt.st        = ADDR_WAIT;
        end
      end
      ADDR_WAIT: begin
        if (LINK.addr_valid) begin
          s_nxt.code                 = LINK.addr;
          s_nxt.dir_out              = LINK.dir_out;
          s_nxt.memory_address_latch =
            {{(`WORD_W-`CODE_W){1'b0}}, LINK.addr};
          s_nxt.mem_req              = 1'b1;
          s_nxt.mem_we               = 1'b0;
          s_nxt.mem_addr             =
            {{(`WORD_W-`CODE_W){1'b0}}, LINK.addr};
          s_nxt.st                   = WC_RD;
        end
      end
      WC_RD: begin
        if (mem_taken) begin
          s_nxt.wc_carry  = inc_sum[`WORD_W];
          s_nxt.mem_we    = 1'b1;
          s_nxt.mem_wdata = inc_sum[`WORD_W-1:0];
          s_nxt.st        = WC_WR;
        end
      end
      WC_WR: begin
        if (mem_taken) begin
          s_nxt.memory_address_latch = code_word + `WORD_ONE;
          s_nxt.mem_we               = 1'b0;
          s_nxt.mem_addr             = code_word + `WORD_ONE;
          s_nxt.st                   = CA_RD;
        end
      end
      CA_RD: begin
        if (mem_taken) begin
          s_nxt.memory_address_latch = inc_sum[`WORD_W-1:0];
          s_nxt.mem_we               = 1'b1;
          s_nxt.mem_wdata            = inc_sum[`WORD_W-1:0];
          s_nxt.st                   = CA_WR;
        end
      end
      CA_WR: begin
        if (mem_taken) begin
          s_nxt.mem_addr  = s_r.memory_address_latch;
          s_nxt.mem_we    = !s_r.dir_out;
          s_nxt.mem_wdata = LINK.wdata;
          s_nxt.st        = DATA_MEM;
        end
      end
      DATA_MEM: begin
        if (mem_taken) begin
          s_nxt.mem_req = 1'b0;
          s_nxt.mem_we  = 1'b0;
          if (s_r.dir_out) begin
            s_nxt.rdata  = MEM_RDATA;
            s_nxt.settle = SETTLE_LAST;
            s_nxt.st     = SETTLE;
          end else begin
            s_nxt.st = FINISH;
          end
        end
      end
      SETTLE: begin
        // bus and gates settle a full i/o cycle before the strobe
        if (s_r.settle == '0) begin
          s_nxt.strobe = 1'b1;
          s_nxt.st     = FINISH;
        end else begin
          s_nxt.settle = s_r.settle - `SETTLE_CNT_W'(1);
        end
      end
      FINISH: begin
        s_nxt.done      = 1'b1;
        s_nxt.overflow  = s_r.wc_carry;
        s_nxt.block_end = s_r.wc_carry;
        s_nxt.wc_carry  = 1'b0;
        s_nxt.st        = IDLE;
      end
      default: begin
        s_nxt.st      = IDLE;
        s_nxt.mem_req = 1'b0;
      end
    endcase
    // busy flag kept in a register so the pin comes straight off a flop
    s_nxt.busy = s_nxt.st != IDLE;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_r <= '{
        st:                   IDLE,
        code:                 `CODE_ZERO,
        memory_address_latch: `WORD_ZERO,
        dir_out:              1'b0,
        wc_carry:             1'b0,
        settle:               '0,
        grant:                1'b0,
        rdata:                `WORD_ZERO,
        strobe:               1'b0,
        done:                 1'b0,
        overflow:             1'b0,
        block_end:            1'b0,
        cpu_grant:            1'b0,
        busy:                 1'b0,
        svc:                  SVC_MAIN,
        vpi_level:            3'h0,
        mem_req:              1'b0,
        mem_we:               1'b0,
        mem_addr:             `WORD_ZERO,
        mem_wdata:            `WORD_ZERO
      };
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  assign LINK.grant    = s_r.grant;
  assign LINK.rdata    = s_r.rdata;
  assign LINK.strobe   = s_r.strobe;
  assign LINK.done     = s_r.done;
  assign LINK.overflow = s_r.overflow;
  assign CPU_MEM_GRANT = s_r.cpu_grant;
  assign SERVICE_CLASS = s_r.svc;
  assign VPI_LEVEL     = s_r.vpi_level;
  assign CHAN_BUSY     = s_r.busy;
  assign MEM_REQ       = s_r.mem_req;
  assign MEM_WE        = s_r.mem_we;
  assign MEM_ADDR      = s_r.mem_addr;
  assign MEM_WDATA     = s_r.mem_wdata;
  assign BLOCK_END_IRQ = s_r.block_end;

endmodule : chan_ctrl

// File: rtl/chan_periph.sv
// one peripheral controller on the chained block channel
// assumes the upstream side of the link is chan_ctrl or an earlier
// peripheral; downstream peripherals join through the CHAIN ports
`include "chan_cfg.svh"
module chan_periph (
  input  wire logic               CLK,
  input  wire logic               SYS_RST,
  input  wire logic               CE,
  chan_link_if.periph             LINK,
  input  wire logic               ENABLE,
  input  wire logic               DIR_OUT,
  input  wire chan_pkg::code_type WC_CODE,
  input  wire chan_pkg::word_type IN_DATA,
  input  wire logic               IN_FULL,
  input  wire logic               OUT_READY,
  output logic                    IN_TAKEN,
  output chan_pkg::word_type      OUT_DATA,
  output logic                    OUT_VALID,
  output logic                    BLOCK_DONE,
  input  wire logic               CHAIN_REQ_IN,
  output logic                    CHAIN_GRANT_OUT
);
  import chan_pkg::*;

  typedef enum logic [1:0] {
    P_IDLE,
    P_XFER,
    P_HOLD
  } periph_state_type;

  typedef struct packed {
    periph_state_type st;
    logic             req;
    logic             own;
    logic             addr_valid;
    code_type         addr;
    logic             dir_out;
    logic             in_taken;
    word_type         out_data;
    logic             out_valid;
    logic             stopped;
    logic             chain_grant;
    word_type         wdata;
  } periph_regs_type;

  periph_regs_type s_r;
  periph_regs_type s_nxt;
  logic            want;

  // enabled, not stopped, and with a full or free buffer
  assign want = ENABLE && !s_r.stopped &&
                (DIR_OUT ? OUT_READY : IN_FULL);

  always_comb begin
    s_nxt             = s_r;
    s_nxt.addr_valid  = 1'b0;
    s_nxt.in_taken    = 1'b0;
    s_nxt.out_valid   = 1'b0;
    s_nxt.chain_grant = 1'b0;
    s_nxt.wdata       = IN_DATA;
    if (!ENABLE) begin
      s_nxt.stopped = 1'b0;
    end
    case (s_r.st)
      P_IDLE: begin
        s_nxt.own = want;
        s_nxt.req = want || CHAIN_REQ_IN;
        if (LINK.grant) begin
          if (s_r.own) begin
            s_nxt.addr_valid = 1'b1;
            s_nxt.addr       = WC_CODE;
            s_nxt.dir_out    = DIR_OUT;
            s_nxt.req        = CHAIN_REQ_IN;
            s_nxt.st         = P_XFER;
          end else begin
            s_nxt.chain_grant = 1'b1;
          end
        end
      end
      P_XFER: begin
        s_nxt.own = 1'b0;
        s_nxt.req = CHAIN_REQ_IN;
        if (LINK.strobe) begin
          s_nxt.out_data  = LINK.rdata;
          s_nxt.out_valid = 1'b1;
        end
        if (LINK.done) begin
          s_nxt.in_taken = !s_r.dir_out;
          s_nxt.stopped  = LINK.overflow;
          s_nxt.st       = P_HOLD;
        end
      end
      P_HOLD: begin
        // one quiet cycle so the user can drop its full flag
        s_nxt.req = CHAIN_REQ_IN;
        s_nxt.st  = P_IDLE;
      end
      default: begin
        s_nxt.st = P_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) begin
      s_r <= '{
        st:          P_IDLE,
        req:         1'b0,
        own:         1'b0,
        addr_valid:  1'b0,
        addr:        `CODE_ZERO,
        dir_out:     1'b0,
        in_taken:    1'b0,
        out_data:    `WORD_ZERO,
        out_valid:   1'b0,
        stopped:     1'b0,
        chain_grant: 1'b0,
        wdata:       `WORD_ZERO
      };
    end else if (CE) begin
      s_r <= s_nxt;
    end
  end

  assign LINK.req        = s_r.req;
  assign LINK.addr_valid = s_r.addr_valid;
  assign LINK.addr       = s_r.addr;
  assign LINK.dir_out    = s_r.dir_out;
  assign LINK.wdata      = s_r.wdata; // user holds IN_DATA while IN_FULL
  assign IN_TAKEN        = s_r.in_taken;
  assign OUT_DATA        = s_r.out_data;
  assign OUT_VALID       = s_r.out_valid;
  assign BLOCK_DONE      = s_r.stopped;
  assign CHAIN_GRANT_OUT = s_r.chain_grant;

endmodule : chan_periph

// File: testbench/chan_link_sva.sv
// assertions on the block channel link between controller and peripheral
// assumes one clock, async high reset, one peripheral with no chain below
module chan_link_sva (
  input wire logic CLK,
  input wire logic SYS_RST,
  input wire logic req,
  input wire logic grant,
  input wire logic addr_valid,
  input wire logic dir_out,
  input wire logic strobe,
  input wire logic done,
  input wire logic overflow
);
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {
    logic [8:0] since;
    logic       busy;
  } help_type;
  help_type st_r;
  help_type st_nxt;

  default clocking @(posedge CLK); endclocking
  default disable iff (SYS_RST);

  // cycles since the last code pulse, saturating at 511 so the count never wraps
  always_comb begin
    st_nxt = st_r;
    if (addr_valid) st_nxt.since = 9'h001;
    else if (st_r.since != 9'h1FF) st_nxt.since = st_r.since + 9'h001;
    if (grant) st_nxt.busy = 1'b1;
    else if (done) st_nxt.busy = 1'b0;
  end

  always_ff @(posedge CLK or posedge SYS_RST) begin
    if (SYS_RST) st_r <= {9'h1FF, 1'b0};
    else st_r <= st_nxt;
  end

  property p_grant_cause; grant |-> $past(req); endproperty
  a_grant_cause: assert property (p_grant_cause)
    else $error("grant without request");
  property p_grant_pulse; grant |=> !grant; endproperty
  a_grant_pulse: assert property (p_grant_pulse)
    else $error("grant longer than one cycle");
  property p_code_cause; addr_valid |-> $past(grant); endproperty
  a_code_cause: assert property (p_code_cause)
    else $error("code without grant");
  property p_grant_code; grant |=> addr_valid; endproperty
  a_grant_code: assert property (p_grant_code)
    else $error("no code after grant");
  property p_ovf_done; overflow |-> done; endproperty
  a_ovf_done: assert property (p_ovf_done)
    else $error("rollover outside done");
  property p_in_bound; addr_valid && !dir_out |-> ##[7:60] done; endproperty
  a_in_bound: assert property (p_in_bound)
    else $error("input transfer did not finish");
  property p_out_bound; addr_valid && dir_out |-> ##[200:700] strobe;
  endproperty
  a_out_bound: assert property (p_out_bound)
    else $error("output strobe missing");
  property p_out_settle; strobe |-> st_r.since >= 9'h0CE; endproperty
  a_out_settle: assert property (p_out_settle)
    else $error("strobe before settle time");
  property p_strobe_done; strobe |=> done; endproperty
  a_strobe_done: assert property (p_strobe_done)
    else $error("no done after strobe");
  property p_one_xfer; grant |-> !st_r.busy; endproperty
  a_one_xfer: assert property (p_one_xfer)
    else $error("grant during a transfer");
endmodule : chan_link_sva

// File: testbench/multicycle_data_channel_bench.sv
// self-checking bench: controller and one peripheral across the link
// assumes design files and chan_link_sva.sv compiled first
`include "chan_cfg.svh"

module multicycle_data_channel_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import chan_pkg::*;

  logic                   clk = 1'b0;
  logic                   sys_rst = 1'b1;
  logic                   rtc_req = 1'b0;
  logic [`VPI_LEVELS-1:0] vpi_req = 8'h00;
  logic                   shared_req = 1'b0;
  logic                   other_busy = 1'b0;
  logic                   cpu_req = 1'b1;
  logic                   ce = 1'b1;
  logic                   enable = 1'b0;
  logic                   dir_out = 1'b0;
  logic                   in_full = 1'b0;
  logic                   out_ready = 1'b0;
  logic                   mem_ack = 1'b1;
  logic                   stall = 1'b0;
  code_type               wc_code = 15'h0004;
  word_type               in_data = 18'h00000;
  logic                   cpu_grant, chan_busy, mem_req, mem_we, irq;
  logic                   in_taken, out_valid, block_done;
  logic                   irq_seen, gnt_seen, chan_seen, cpu_bad;
  svc_class_type          svc;
  logic [2:0]             vpi_level;
  word_type               mem_addr, mem_wdata, mem_rdata, out_data, out_word;
  word_type               mem [0:63];
  int                     n, failures = 0, cmp_count = 0;

  chan_link_if link ();

  chan_ctrl i_chan_ctrl (.CLK(clk), .SYS_RST(sys_rst), .CE(ce),
    .LINK(link), .RTC_REQ(rtc_req), .VPI_REQ(vpi_req),
    .SHARED_INT_REQ(shared_req), .OTHER_BUSY(other_busy),
    .CPU_MEM_REQ(cpu_req), .CPU_MEM_GRANT(cpu_grant), .SERVICE_CLASS(svc),
    .VPI_LEVEL(vpi_level), .CHAN_BUSY(chan_busy), .MEM_REQ(mem_req),
    .MEM_WE(mem_we), .MEM_ADDR(mem_addr), .MEM_WDATA(mem_wdata),
    .MEM_RDATA(mem_rdata), .MEM_ACK(mem_ack), .BLOCK_END_IRQ(irq));

  chan_periph i_chan_periph (.CLK(clk), .SYS_RST(sys_rst), .CE(ce),
    .LINK(link), .ENABLE(enable), .DIR_OUT(dir_out), .WC_CODE(wc_code),
    .IN_DATA(in_data), .IN_FULL(in_full), .OUT_READY(out_ready),
    .IN_TAKEN(in_taken), .OUT_DATA(out_data), .OUT_VALID(out_valid),
    .BLOCK_DONE(block_done), .CHAIN_REQ_IN(1'b0), .CHAIN_GRANT_OUT());

  chan_link_sva i_chan_link_sva (.CLK(clk), .SYS_RST(sys_rst),
    .req(link.req), .grant(link.grant), .addr_valid(link.addr_valid),
    .dir_out(link.dir_out), .strobe(link.strobe), .done(link.done),
    .overflow(link.overflow));

  always #2.5 clk = ~clk;

  // memory model; data bus shows inverted junk outside a taken cycle
  assign mem_rdata = (mem_req && mem_ack) ? mem[mem_addr[5:0]]
                                          : ~mem[mem_addr[5:0]];
  always @(posedge clk) begin
    if (mem_req && mem_ack && mem_we) mem[mem_addr[5:0]] <= mem_wdata;
  end
  always @(negedge clk) begin
    mem_ack <= stall ? ~mem_ack : 1'b1;
    if (irq) irq_seen <= 1'b1;
    if (link.grant) gnt_seen <= 1'b1;
    if (svc === SVC_CHAN) chan_seen <= 1'b1;
    if (cpu_grant && chan_busy) cpu_bad <= 1'b1;
  end

  task automatic check(input string what, input word_type seen,
                       input word_type exp);
    cmp_count++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // one word from the peripheral user side; n holds cycles taken
  task automatic xfer(input logic dir, input word_type d);
    @(negedge clk);
    dir_out = dir;
    in_data = d;
    in_full = !dir;
    out_ready = dir;
    irq_seen = 1'b0;
    chan_seen = 1'b0;
    for (n = 0; n < 900 && !(in_taken || out_valid); n++) @(negedge clk);
    out_word = out_data;
    in_full = 1'b0;
    repeat (3) @(negedge clk);
  endtask : xfer

  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  initial begin
    svc_class_type exp_cls [4];
    exp_cls = '{SVC_RTC, SVC_VPI, SVC_SHARED, SVC_MAIN};
    cpu_bad = 1'b0;
    repeat (5) @(negedge clk);
    sys_rst = 1'b0;
    in_full = 1'b1;
    repeat (20) @(negedge clk);
    check("req while disabled", word_type'(link.req), 18'h00000);
    in_full = 1'b0;
    enable = 1'b1;
    repeat (20) @(negedge clk);
    check("req buffer empty", word_type'(link.req), 18'h00000);
    for (int i = 0; i < 4; i++) begin
      rtc_req = (i < 1);
      vpi_req = (i < 2) ? 8'h28 : 8'h00;
      shared_req = (i < 3);
      repeat (4) @(negedge clk);
      check("class", word_type'(svc), word_type'(exp_cls[i]));
      if (i == 1) check("level", word_type'(vpi_level), 18'h00003);
    end
    ce = 1'b0;
    rtc_req = 1'b1;
    repeat (4) @(negedge clk);
    check("frozen", word_type'(svc), word_type'(SVC_MAIN));
    ce = 1'b1;
    repeat (4) @(negedge clk);
    check("thawed", word_type'(svc), word_type'(SVC_RTC));
    $display("test gating and ranking done");
    rtc_req = 1'b1;
    vpi_req = 8'hFF;
    shared_req = 1'b1;
    mem[4] = 18'h3FFFE;
    mem[5] = 18'h0000F;
    xfer(1'b0, 18'h2AAAA);
    check("count one", mem[4], 18'h3FFFF);
    check("address one", mem[5], 18'h00010);
    check("word one", mem[16], 18'h2AAAA);
    check("channel first", word_type'(chan_seen), 18'h00001);
    check("early irq", word_type'(irq_seen), 18'h00000);
    xfer(1'b0, 18'h15555);
    check("count wrapped", mem[4], 18'h00000);
    check("word two", mem[17], 18'h15555);
    check("block irq", word_type'(irq_seen), 18'h00001);
    check("stopped", word_type'(block_done), 18'h00001);
    check("cpu locked", word_type'(cpu_bad), 18'h00000);
    xfer(1'b0, 18'h3FFFF);
    check("no word after rollover", word_type'(n), 18'h00384);
    check("address held", mem[5], 18'h00011);
    $display("test input block done");
    enable = 1'b0;
    @(negedge clk);
    enable = 1'b1;
    mem[4] = 18'h3FFFF;
    mem[5] = 18'h0001F;
    mem[32] = 18'h3C3C3;
    stall = 1'b1;
    xfer(1'b1, 18'h00000);
    stall = 1'b0;
    check("output word", out_word, 18'h3C3C3);
    check("settle time", word_type'(n >= `IOP_CYCLE_CLK + 10), 18'h00001);
    check("output address", mem[5], 18'h00020);
    check("output irq", word_type'(irq_seen), 18'h00001);
    $display("test output block done");
    enable = 1'b0;
    @(negedge clk);
    enable = 1'b1;
    mem[4] = 18'h3FFFF;
    mem[5] = 18'h0002F;
    other_busy = 1'b1;
    dir_out = 1'b0;
    in_full = 1'b1;
    gnt_seen = 1'b0;
    repeat (30) @(negedge clk);
    check("waits for activity", word_type'(gnt_seen), 18'h00000);
    other_busy = 1'b0;
    xfer(1'b0, 18'h12345);
    check("served after", mem[48], 18'h12345);
    $display("test wait on activity done");
    end_sim();
  end

  // whole run is about 1300 cycles; cut off well beyond that
  initial begin
    repeat (20000) @(posedge clk);
    failures++;
    end_sim();
  end
endmodule : multicycle_data_channel_bench
